// ### core/afe_phase_dither_control.sv
// apb register bank steering front-end clamp, midscale, dither and sampling phase
`timescale 1ns/1ps
`default_nettype none
module afe_phase_dither_control
(
  // clock and reset
  input  wire logic                      mclk_in,
  input  wire logic                      rst_n_in,
  // apb slave
  input  wire logic                      psel_in,
  input  wire logic                      penable_in,
  input  wire logic                      pwrite_in,
  input  wire logic [31:0]               paddr_in,
  input  wire logic [31:0]               pwdata_in,
  output logic [31:0]                    prdata_out,
  output logic                           pready_out,
  output logic                           pslverr_out,
  // timing and measurement
  input  wire front_end_control_pkg::afe_timing_t timing_in,
  input  wire logic [31:0]               phase_result_in,
  // front-end controls
  output logic [9:0]                     phase_edge_threshold_out,
  output logic                           reference_input_select_out,
  output logic                           clamp_enable_out,
  output logic                           auto_black_level_loop_out,
  output logic [2:0]                     midscale_out,
  output logic [3:0]                     dither_value_out,
  output logic [11:0]                    pixels_per_line_out,
  output logic [5:0]                     sample_phase_out
);
  import front_end_control_pkg::*;

  afe_state_t state_r;
  afe_state_t state_nxt;

  logic [7:0] idx;
  logic       setup;
  logic       wr;
  logic       advance;
  logic       hold;

  function automatic logic [15:0] lfsr_step(input logic [15:0] v);
    lfsr_step = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction

  function automatic logic mapped(input logic [7:0] i);
    mapped = (i == IDX_CONFIG) || (i == IDX_THRESHOLD)
          || (i >= IDX_RESULT3 && i <= IDX_RESULT0)
          || (i >= IDX_FRONT_END && i <= IDX_PHASE);
  endfunction

  // word aligned: index sits above the two byte bits
  assign idx   = paddr_in[9:2];
  assign setup = psel_in & ~penable_in;
  assign wr    = psel_in & penable_in & pwrite_in;

  // read data is captured in setup, so every access ends in one cycle
  assign pready_out  = psel_in & penable_in;
  assign prdata_out  = state_r.rdata;
  assign pslverr_out = psel_in & penable_in & state_r.slverr;

  always_comb
  begin
    state_nxt = state_r;
    hold      = timing_in.holdover | timing_in.copy_protect;
    // RQ9 dither advance rate
    case (state_r.dither_ctl[DT_RATE_LO +: 2])
      RATE_PIXEL: advance = timing_in.pixel;
      RATE_HSYNC: advance = timing_in.hsync;
      default:    advance = timing_in.vsync;
    endcase

    if (setup)
    begin
      state_nxt.slverr = ~mapped(idx) | (pwrite_in & (idx >= IDX_RESULT3) & (idx <= IDX_RESULT0));
      case (idx)
        IDX_CONFIG:    state_nxt.rdata = {24'h000000, state_r.config_reg};
        IDX_THRESHOLD: state_nxt.rdata = {24'h000000, state_r.threshold};
        IDX_RESULT3:   state_nxt.rdata = {24'h000000, phase_result_in[31:24]};
        IDX_RESULT2:   state_nxt.rdata = {24'h000000, phase_result_in[23:16]};
        IDX_RESULT1:   state_nxt.rdata = {24'h000000, phase_result_in[15:8]};
        IDX_RESULT0:   state_nxt.rdata = {24'h000000, phase_result_in[7:0]};
        IDX_FRONT_END: state_nxt.rdata = {24'h000000, state_r.front_end};
        IDX_DITHER:    state_nxt.rdata = {24'h000000, state_r.dither_ctl};
        IDX_LINE_PIX:  state_nxt.rdata = {20'h00000, state_r.line_pix};
        IDX_PHASE:     state_nxt.rdata = {26'h0000000, state_r.phase};
        default:       state_nxt.rdata = 32'h00000000;
      endcase
    end

    if (wr)
    begin
      // RQ2 result bytes take no write
      case (idx)
        IDX_CONFIG:    state_nxt.config_reg = pwdata_in[7:0];
        IDX_THRESHOLD: state_nxt.threshold  = pwdata_in[7:0];
        IDX_FRONT_END: state_nxt.front_end  = pwdata_in[7:0];
        IDX_DITHER:    state_nxt.dither_ctl = pwdata_in[7:0];
        // RQ12 only line length is exposed
        IDX_LINE_PIX:  state_nxt.line_pix   = pwdata_in[11:0];
        // RQ11 six bits give 64 positions
        IDX_PHASE:     state_nxt.phase      = pwdata_in[5:0];
        default:       state_nxt.slverr     = state_r.slverr;
      endcase
    end

    // RQ10 seed held while the reset bit is high
    if (state_r.dither_ctl[DT_SEED_BIT])
    begin
      state_nxt.lfsr = DITHER_SEED;
    end
    // RQ7 generator runs only when enabled
    else if (state_r.dither_ctl[DT_EN_BIT] && advance)
    begin
      state_nxt.lfsr = lfsr_step(state_r.lfsr);
    end

    // RQ14 outputs follow the registers one clock later
    // RQ1 threshold times four
    state_nxt.edge_thr = {state_r.threshold, 2'b00};
    // RQ3 calibration reference
    state_nxt.ref_sel  = state_r.front_end[FE_REF_BIT];
    // RQ4 suspend in holdover unless kept on
    state_nxt.clamp_en = ~hold | state_r.front_end[FE_HOLD_BIT];
    state_nxt.blk_en   = ~hold | state_r.front_end[FE_HOLD_BIT];
    // RQ6 override picks per-channel bits
    if (state_r.front_end[FE_OVR_BIT])
    begin
      // RQ5 blue, green, red order
      state_nxt.midscale = state_r.front_end[FE_MID_LO +: 3];
    end
    else
    begin
      // RQ13 colour-difference mode drops shift on chroma
      state_nxt.midscale = state_r.config_reg[CFG_YUV_BIT] ? 3'b010 : 3'b111;
    end
    // RQ7 zero dither when disabled
    if (!state_r.dither_ctl[DT_EN_BIT])
    begin
      state_nxt.dither_val = 4'h0;
    end
    // RQ8 8 LSB amplitude keeps three bits
    else if (state_r.dither_ctl[DT_AMP_BIT])
    begin
      state_nxt.dither_val = {1'b0, state_r.lfsr[2:0]};
    end
    else
    begin
      state_nxt.dither_val = state_r.lfsr[3:0];
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      state_r            <= '0;
      state_r.config_reg <= RST_CONFIG;
      state_r.threshold  <= RST_THRESHOLD;
      state_r.front_end  <= RST_FRONT_END;
      state_r.dither_ctl <= RST_DITHER;
      state_r.line_pix   <= RST_LINE_PIX;
      state_r.phase      <= RST_PHASE;
      state_r.lfsr       <= DITHER_SEED;
      state_r.edge_thr   <= {RST_THRESHOLD, 2'b00};
      state_r.midscale   <= 3'b111;
      state_r.clamp_en   <= 1'b1;
      state_r.blk_en     <= 1'b1;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  assign phase_edge_threshold_out   = state_r.edge_thr;
  assign reference_input_select_out = state_r.ref_sel;
  assign clamp_enable_out           = state_r.clamp_en;
  assign auto_black_level_loop_out  = state_r.blk_en;
  assign midscale_out               = state_r.midscale;
  assign dither_value_out           = state_r.dither_val;
  assign pixels_per_line_out        = state_r.line_pix;
  assign sample_phase_out           = state_r.phase;
endmodule
`default_nettype wire

// ### core/front_end_control_pkg.sv
// package: register map, field positions and state for the front-end control bank
// Summary of operation
// RQ1 - the 10-bit phase edge threshold is the programmed 8-bit value times four.
// RQ2 - the four phase result registers are read-only and ignore writes.
// RQ3 - front-end bit 1 routes all three converter inputs to the calibration reference.
// RQ4 - front-end bit 2 clear suspends clamping and black-level loop in holdover.
// RQ5 - front-end bits 4, 5, 6 give the blue, green, red half-scale shift.
// RQ6 - front-end bit 7 clear takes the shift from the colour format, not bits 6:4.
// RQ7 - converter bit 0 enables dither, and dither is off after reset.
// RQ8 - converter bit 1 picks dither amplitude, 16 LSBs when clear, 8 when set.
// RQ9 - converter bits 3:2 advance dither every pixel, hsync, or vsync.
// RQ10 - software pulses converter bit 4 high then low to restart the dither seed.
// RQ11 - the sampling clock loop offers 64 phase positions per pixel.
// RQ12 - the loop locks on its own and only needs the pixels per line.
// RQ13 - a configuration bit selects colour-difference mode with mid-scale chroma; the bank drops the chroma shift and shifts green only.
// RQ14 - control changes take effect on the clock after the write completes; pixels per line and sample phase change on the completing clock itself.
package front_end_control_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_CONFIG    = 8'h10;
  localparam logic [7:0] IDX_THRESHOLD = 8'h56;
  localparam logic [7:0] IDX_RESULT3   = 8'h57;
  localparam logic [7:0] IDX_RESULT2   = 8'h58;
  localparam logic [7:0] IDX_RESULT1   = 8'h59;
  localparam logic [7:0] IDX_RESULT0   = 8'h5a;
  localparam logic [7:0] IDX_FRONT_END = 8'h60;
  localparam logic [7:0] IDX_DITHER    = 8'h61;
  localparam logic [7:0] IDX_LINE_PIX  = 8'h62;
  localparam logic [7:0] IDX_PHASE     = 8'h63;
  // reset values
  localparam logic [7:0]  RST_THRESHOLD = 8'h0a;
  localparam logic [7:0]  RST_FRONT_END = 8'h00;
  localparam logic [7:0]  RST_DITHER    = 8'h00;
  localparam logic [7:0]  RST_CONFIG    = 8'h00;
  localparam logic [11:0] RST_LINE_PIX  = 12'h698;
  localparam logic [5:0]  RST_PHASE     = 6'h00;
  localparam logic [15:0] DITHER_SEED   = 16'hace1;
  // field positions
  localparam int CFG_YUV_BIT  = 4;
  localparam int FE_REF_BIT   = 1;
  localparam int FE_HOLD_BIT  = 2;
  localparam int FE_MID_LO    = 4;
  localparam int FE_OVR_BIT   = 7;
  localparam int DT_EN_BIT    = 0;
  localparam int DT_AMP_BIT   = 1;
  localparam int DT_RATE_LO   = 2;
  localparam int DT_SEED_BIT  = 4;
  localparam int THR_SHIFT    = 2;
  localparam int PHASE_STEPS  = 64;
  localparam logic [1:0] RATE_PIXEL = 2'b00;
  localparam logic [1:0] RATE_HSYNC = 2'b01;

  // whole state of the bank
  typedef struct packed {
    logic [7:0]  config_reg;
    logic [7:0]  threshold;
    logic [7:0]  front_end;
    logic [7:0]  dither_ctl;
    logic [11:0] line_pix;
    logic [5:0]  phase;
    logic [15:0] lfsr;
    logic [31:0] rdata;
    logic        slverr;
    logic [9:0]  edge_thr;
    logic [2:0]  midscale;
    logic        ref_sel;
    logic        clamp_en;
    logic        blk_en;
    logic [3:0]  dither_val;
  } afe_state_t;

  // measurement inputs that travel together
  typedef struct packed {
    logic pixel;
    logic hsync;
    logic vsync;
    logic holdover;
    logic copy_protect;
  } afe_timing_t;
endpackage

// ### tb/afe_bank_chk.sv
// checker: control output assertions for the register bank
`timescale 1ns/1ps
`default_nettype none
module afe_bank_chk
(
  // watched ports
  input wire logic                      mclk_in,
  input wire logic                      rst_n_in,
  input wire logic                      psel_in,
  input wire logic                      penable_in,
  input wire logic                      pwrite_in,
  input wire logic [31:0]               paddr_in,
  input wire logic [31:0]               pwdata_in,
  input wire logic                      pslverr_out,
  input wire front_end_control_pkg::afe_timing_t timing_in,
  input wire logic [9:0]                phase_edge_threshold_out,
  input wire logic                      reference_input_select_out,
  input wire logic                      clamp_enable_out,
  input wire logic                      auto_black_level_loop_out,
  input wire logic [2:0]                midscale_out,
  input wire logic [3:0]                dither_value_out
);
  import front_end_control_pkg::*;
  logic       wr;
  logic [7:0] ix;
  // outputs follow a write one clock after the register lands
  assign wr = psel_in & penable_in & pwrite_in;
  assign ix = paddr_in[9:2];
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);
  thr_scaled_a: assert property (wr && ix == IDX_THRESHOLD |=>
    ##1 phase_edge_threshold_out == {$past(pwdata_in[7:0], 2), 2'b00}) else $error("threshold not scaled");
  result_ro_a: assert property (wr && ix >= IDX_RESULT3 && ix <= IDX_RESULT0 |-> pslverr_out)
    else $error("result write not refused");
  ref_select_a: assert property (wr && ix == IDX_FRONT_END |=>
    ##1 reference_input_select_out == $past(pwdata_in[1], 2)) else $error("reference select wrong");
  hold_clamp_a: assert property (!(timing_in.holdover | timing_in.copy_protect) |=>
    clamp_enable_out && auto_black_level_loop_out) else $error("clamp off outside holdover");
  mid_override_a: assert property (wr && ix == IDX_FRONT_END && pwdata_in[7] |=>
    ##1 midscale_out == $past(pwdata_in[6:4], 2)) else $error("midscale override wrong");
  mid_format_a: assert property (wr && ix == IDX_FRONT_END && !pwdata_in[7] |=>
    ##1 midscale_out inside {3'b111, 3'b010}) else $error("midscale ignores format");
  dither_off_a: assert property (wr && ix == IDX_DITHER && !pwdata_in[0] |=>
    ##1 dither_value_out == 4'h0) else $error("dither not off");
  dither_amp_a: assert property (wr && ix == IDX_DITHER && pwdata_in[1] |=>
    ##1 !dither_value_out[3]) else $error("dither amplitude too large");
endmodule
bind afe_phase_dither_control afe_bank_chk u_chk (.mclk_in, .rst_n_in, .psel_in, .penable_in, .pwrite_in,
  .paddr_in, .pwdata_in, .pslverr_out, .timing_in, .phase_edge_threshold_out, .reference_input_select_out,
  .clamp_enable_out, .auto_black_level_loop_out, .midscale_out, .dither_value_out);
`default_nettype wire

// ### tb/afe_video_source.sv
// partner: video timing pulses and phase measurement word
`timescale 1ns/1ps
`default_nettype none
module afe_video_source
#(parameter logic [31:0] RESULT_WORD = 32'h1234_5678)
(
  // control and outputs
  input  wire logic                     mclk_in,
  input  wire logic                     run_in,
  input  wire logic                     hold_in,
  input  wire logic                     protect_in,
  output var front_end_control_pkg::afe_timing_t timing_out,
  output logic [31:0]                   result_out
);
  import front_end_control_pkg::*;
  logic [5:0] cnt_r = 6'h00;
  always_ff @(posedge mclk_in)
  begin
    cnt_r <= run_in ? cnt_r + 6'h01 : 6'h00;
  end
  // pulses only while running, so the bench can freeze the sequence
  assign timing_out = '{pixel: run_in & cnt_r[0], hsync: run_in & (cnt_r[3:0] == 4'hf),
    vsync: run_in & (cnt_r == 6'h3f), holdover: hold_in, copy_protect: protect_in};
  assign result_out = RESULT_WORD;
endmodule
`default_nettype wire

// ### tb/afe_phase_dither_control_test.sv
// testbench: register access and control output checks
`timescale 1ns/1ps
`default_nettype none
module afe_phase_dither_control_test;
  import front_end_control_pkg::*;
  localparam logic [31:0] WORD = 32'h1234_5678;
  logic mclk_in = 1'b0, rst_n_in = 1'b0, psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0, run = 1'b0;
  logic hold = 1'b0, prot = 1'b0, err, pready_out, pslverr_out, reference_input_select_out;
  logic clamp_enable_out, auto_black_level_loop_out;
  logic [31:0] paddr_in = 32'h0, pwdata_in = 32'h0, prdata_out, rd, phase_result_in;
  logic [9:0] phase_edge_threshold_out;
  logic [2:0] midscale_out;
  logic [3:0] dither_value_out;
  logic [11:0] pixels_per_line_out;
  logic [5:0] sample_phase_out;
  afe_timing_t timing_in;
  int miscompares = 0, num_checks = 0;
  always #2 mclk_in = ~mclk_in;
  afe_video_source #(.RESULT_WORD(WORD)) SRC (.mclk_in, .run_in(run), .hold_in(hold), .protect_in(prot),
    .timing_out(timing_in), .result_out(phase_result_in));
  afe_phase_dither_control DUT (.mclk_in, .rst_n_in, .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in,
    .prdata_out, .pready_out, .pslverr_out, .timing_in, .phase_result_in, .phase_edge_threshold_out,
    .reference_input_select_out, .clamp_enable_out, .auto_black_level_loop_out, .midscale_out,
    .dither_value_out, .pixels_per_line_out, .sample_phase_out);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] ix, input logic [31:0] wd);
    @(posedge mclk_in);
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= {22'h0, ix, 2'b00};
    pwdata_in <= wd;
    @(posedge mclk_in);
    penable_in <= 1'b1;
    do @(posedge mclk_in); while (pready_out !== 1'b1);
    rd = prdata_out;
    err = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask
  task automatic rdchk(input logic [7:0] ix, input logic [31:0] exp);
    apb(1'b0, ix, 32'h0);
    chk(rd, exp);
  endtask
  // write, then let the derived outputs land
  task automatic wrs(input logic [7:0] ix, input logic [31:0] v);
    apb(1'b1, ix, v);
    repeat (2) @(posedge mclk_in);
    #1;
  endtask
  // reseed, then let the source give three pixel or line pulses; the sequence must move exactly three steps
  task automatic dith(input logic [7:0] ctl, input logic hs, input logic [3:0] exp);
    wrs(IDX_DITHER, {24'h000000, ctl | 8'h10});
    wrs(IDX_DITHER, {24'h000000, ctl});
    @(posedge mclk_in);
    run <= 1'b1;
    repeat (3) @(posedge mclk_in iff (hs ? timing_in.hsync : timing_in.pixel));
    run <= 1'b0;
    repeat (2) @(posedge mclk_in);
    #1;
    chk(dither_value_out, exp);
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    #20000;
    miscompares++;
    end_sim();
  end
  initial
  begin
    repeat (4) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    #1;
    chk(phase_edge_threshold_out, 10'h028);
    chk(dither_value_out, 4'h0);
    chk(pixels_per_line_out, 12'h698);
    rdchk(IDX_THRESHOLD, 32'h0a);
    rdchk(IDX_FRONT_END, 32'h00);
    rdchk(IDX_DITHER, 32'h00);
    wrs(IDX_THRESHOLD, 32'hff);
    chk(phase_edge_threshold_out, 10'h3fc);
    for (int i = 0; i < 4; i++)
    begin
      apb(1'b1, 8'(IDX_RESULT3 + i), 32'hff);
      chk(err, 32'h1);
      rdchk(8'(IDX_RESULT3 + i), (WORD >> (24 - 8 * i)) & 32'hff);
    end
    rdchk(8'h70, 32'h0);
    chk(err, 32'h1);
    wrs(IDX_FRONT_END, 32'h02);
    chk(reference_input_select_out, 32'h1);
    @(posedge mclk_in);
    hold <= 1'b1;
    wrs(IDX_FRONT_END, 32'h00);
    chk({clamp_enable_out, auto_black_level_loop_out}, 32'h0);
    chk(reference_input_select_out, 32'h0);
    wrs(IDX_FRONT_END, 32'h04);
    chk({clamp_enable_out, auto_black_level_loop_out}, 32'h3);
    @(posedge mclk_in);
    hold <= 1'b0;
    prot <= 1'b1;
    wrs(IDX_FRONT_END, 32'h00);
    chk({clamp_enable_out, auto_black_level_loop_out}, 32'h0);
    @(posedge mclk_in);
    prot <= 1'b0;
    repeat (2) @(posedge mclk_in);
    #1;
    chk({clamp_enable_out, auto_black_level_loop_out}, 32'h3);
    wrs(IDX_FRONT_END, 32'hd0);
    chk(midscale_out, 3'b101);
    wrs(IDX_FRONT_END, 32'h50);
    chk(midscale_out, 3'b111);
    wrs(IDX_CONFIG, 32'h10);
    chk(midscale_out, 3'b010);
    wrs(IDX_PHASE, 32'h3f);
    chk(sample_phase_out, 6'h3f);
    wrs(IDX_LINE_PIX, 32'h540);
    chk(pixels_per_line_out, 32'h540);
    rdchk(IDX_LINE_PIX, 32'h540);
    wrs(IDX_DITHER, 32'h19);
    wrs(IDX_DITHER, 32'h09);
    chk(dither_value_out, 4'h1);
    @(posedge mclk_in);
    run <= 1'b1;
    // only frame pulses may step the sequence at this rate
    repeat (3) @(posedge mclk_in iff timing_in.vsync);
    run <= 1'b0;
    repeat (2) @(posedge mclk_in);
    #1;
    chk(dither_value_out, 4'hf);
    wrs(IDX_DITHER, 32'h0b);
    chk(dither_value_out, 4'h7);
    wrs(IDX_DITHER, 32'h0a);
    chk(dither_value_out, 4'h0);
    dith(8'h01, 1'b0, 4'hf);
    dith(8'h05, 1'b1, 4'hf);
    end_sim();
  end
endmodule
`default_nettype wire
